// *** logic/oca_pkg.sv ***
// Constants, field layouts and carrier types of the character attribute renderer
`default_nettype none
package oca_pkg;
    // ---------------------------------------------------------------
    // Register byte offsets and fields
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_OSD_CTRL = 8'h00;   // Screen-level control
    localparam logic [7:0] OFS_BLK_CTRL = 8'h04;   // Per-block control
    localparam logic [7:0] OFS_BORDER_COL = 8'h08; // Border colour, 3 bits
    localparam logic [7:0] OFS_EXTRA_COL = 8'h0C;  // Extra glyph colour, 3 bits
    localparam logic [7:0] OFS_STATUS = 8'h10;     // Flash counter, read only
    localparam int OSD_SHADOW_BIT = 2;    // 1: shadow border, 0: full border
    localparam int OSD_BGFLASH_BIT = 3;   // 1: background flashes too
    localparam int BLK_BORDER_BIT = 2;    // Border on
    localparam int BLK_LUMA2_BIT = 7;     // Secondary luma enable
    localparam int BLK_RATIO2_BIT = 0;    // Pre-divide ratio 2
    localparam int BLK_DOT15_BIT = 1;     // 1.5-period character dot size
    localparam int BLK_MODE_LO = 4;       // Two-bit display mode field
    localparam logic [7:0] OSD_CTRL_RST = 8'h00;
    localparam logic [7:0] BLK_CTRL_RST = 8'h00;
    localparam logic [2:0] COL_RST = 3'h0;
    // ---------------------------------------------------------------
    // Code fields and geometry
    // ---------------------------------------------------------------
    localparam int C1_LUMA_BIT = 4;       // luma_select_field
    localparam int C1_FLASH_BIT = 5;
    localparam int C1_ULINE_BIT = 6;
    localparam int C1_ITALIC_BIT = 7;
    localparam int C2_EXTRA_BIT = 3;      // extra_code_bit3_field
    localparam logic [4:0] ULINE_ROW_A = 5'h16; // 23rd dot row, zero based
    localparam logic [4:0] ULINE_ROW_B = 5'h17; // 24th dot row
    localparam logic [4:0] LAST_ROW = 5'h19;    // 26 rows per cell
    localparam logic [5:0] LAST_CHAR = 6'h27;   // 40th character
    localparam int SLANT_DIV = 5;               // Rows per slant step
    localparam logic [6:0] FLASH_ON_VS = 7'h30;  // 48 vsync periods shown
    localparam logic [6:0] FLASH_OFF_VS = 7'h10; // 16 vsync periods blanked
    // Extended-mode eight-entry colour table, index = code, value = {B,G,R}
    localparam logic [23:0] EXT_COLOR_LUT = 24'hFB_B6_88;
    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {OCA_CAPTION, OCA_PLAIN, OCA_EXTENDED, OCA_RSVD} oca_mode_e;
    // One dot of the character stream, held for every clock of the dot
    typedef struct packed {
        logic active;          // Inside a character cell
        logic [5:0] char_pos;  // Character index in the block, 0..39
        logic [4:0] row;       // Dot row in the cell, 0..25
        logic [3:0] col;       // Dot column in the cell, 0..15
        logic [7:0] code1;     // Colour code 1
        logic [3:0] code2;     // Colour code 2
        logic prev_italic;     // Left neighbour italic
        logic next_italic;     // Right neighbour italic
        logic [15:0] font_row; // Current row, bit i = column i
        logic [15:0] prev_row; // Left neighbour, same row
        logic [15:0] next_row; // Right neighbour, same row
        logic [15:0] above_row;
        logic [15:0] below_row;
        logic [15:0] extra_row; // Extra glyph, same row
    } oca_dot_s;
    // Colour output of one dot
    typedef struct packed {
        logic r;
        logic g;
        logic b;
        logic luma_ctrl_primary;
        logic luma_ctrl_secondary;
    } oca_pix_s;
endpackage : oca_pkg
`default_nettype wire

// *** logic/oca_char_attr.sv ***
// Per-dot colour and attribute renderer with Wishbone register slave
//
// Register access over Wishbone and the register addresses were decided locally.
`default_nettype none
module oca_char_attr (
    input wire logic clk,
    input wire logic arst_n,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Dot stream and vertical sync pulse
    input wire oca_pkg::oca_dot_s dot_i,
    input wire logic vsync_i,
    // Pre-divided dot tick, extra glyph select, pixel out
    output logic dot_tick_o,
    output logic [3:0] extra_sel_o,
    output oca_pkg::oca_pix_s pix_o
);
    // ---------------------------------------------------------------
    // Register slave
    // ---------------------------------------------------------------
    logic [7:0] osd_ctrl_q;     // Screen-level control
    logic [7:0] blk_ctrl_q;     // Block control
    logic [2:0] border_col_q;   // Border colour {B,G,R}
    logic [2:0] extra_col_q;    // Extra glyph colour {B,G,R}
    logic ack_q;                // One-cycle acknowledge
    logic [31:0] rdat_q;        // Registered read data
    logic [6:0] flash_cnt_q;    // Vsync count within phase
    logic flash_off_q;          // High in blanked phase

    wire bus_req = wb_cyc_i && wb_stb_i && !ack_q;
    wire wr_lane0 = bus_req && wb_we_i && wb_sel_i[0]; // Registers sit in lane 0
    wire sel_osd = (wb_adr_i == oca_pkg::OFS_OSD_CTRL);
    wire sel_blk = (wb_adr_i == oca_pkg::OFS_BLK_CTRL);
    wire sel_bcol = (wb_adr_i == oca_pkg::OFS_BORDER_COL);
    wire sel_xcol = (wb_adr_i == oca_pkg::OFS_EXTRA_COL);
    wire sel_stat = (wb_adr_i == oca_pkg::OFS_STATUS);
    // Unmapped offsets read zero and ignore writes, but are still acknowledged
    wire [31:0] rd_mux = sel_osd ? {24'h000000, osd_ctrl_q} :
                         sel_blk ? {24'h000000, blk_ctrl_q} :
                         sel_bcol ? {29'h0, border_col_q} :
                         sel_xcol ? {29'h0, extra_col_q} :
                         sel_stat ? {24'h000000, flash_off_q, flash_cnt_q} : 32'h00000000;

    // Acknowledge one cycle after the request; drops the cycle after
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h00000000;
        end else begin
            ack_q <= bus_req;
            rdat_q <= bus_req ? rd_mux : 32'h00000000;
        end
    end

    // Writes land at the edge that raises ack
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            osd_ctrl_q <= oca_pkg::OSD_CTRL_RST;
            blk_ctrl_q <= oca_pkg::BLK_CTRL_RST;
            border_col_q <= oca_pkg::COL_RST;
            extra_col_q <= oca_pkg::COL_RST;
        end else if (wr_lane0) begin
            if (sel_osd) osd_ctrl_q <= wb_dat_i[7:0];
            if (sel_blk) blk_ctrl_q <= wb_dat_i[7:0];
            if (sel_bcol) border_col_q <= wb_dat_i[2:0];
            if (sel_xcol) extra_col_q <= wb_dat_i[2:0];
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // ---------------------------------------------------------------
    // Configuration decode
    // ---------------------------------------------------------------
    wire ratio2 = blk_ctrl_q[oca_pkg::BLK_RATIO2_BIT];
    wire dot15 = blk_ctrl_q[oca_pkg::BLK_DOT15_BIT];
    wire [1:0] mode_raw = blk_ctrl_q[oca_pkg::BLK_MODE_LO +: 2];
    wire is_cap = (mode_raw == oca_pkg::OCA_CAPTION);
    wire is_ext = (mode_raw == oca_pkg::OCA_EXTENDED);
    wire is_pln = (mode_raw == oca_pkg::OCA_PLAIN);

    // ---------------------------------------------------------------
    // Pre-divider: one tick per dot, two clocks per dot at ratio 2
    // ---------------------------------------------------------------
    logic half_q;  // Second clock of a ratio-2 dot
    logic tick_q;  // Dot tick to the upstream fetch logic
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            half_q <= 1'b0;
            tick_q <= 1'b0;
        end else begin
            half_q <= ratio2 ? !half_q : 1'b0;
            tick_q <= ratio2 ? half_q : 1'b1;
        end
    end
    assign dot_tick_o = tick_q;

    // ---------------------------------------------------------------
    // Flash timer on vertical sync
    // ---------------------------------------------------------------
    wire [6:0] flash_len = flash_off_q ? oca_pkg::FLASH_OFF_VS : oca_pkg::FLASH_ON_VS;
    wire flash_wrap = vsync_i && (flash_cnt_q == flash_len - 7'h01);
    // Count vsync periods, flip phase at end of each
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flash_cnt_q <= 7'h00;
            flash_off_q <= 1'b0;
        end else if (vsync_i) begin
            flash_cnt_q <= flash_wrap ? 7'h00 : flash_cnt_q + 7'h01;
            flash_off_q <= flash_wrap ? !flash_off_q : flash_off_q;
        end
    end

    // ---------------------------------------------------------------
    // Italic slant position
    // ---------------------------------------------------------------
    // Rows counted from the bottom; the top row is shifted furthest right
    wire [4:0] rows_up = oca_pkg::LAST_ROW - dot_i.row;
    wire [4:0] step_full = 5'((rows_up) / oca_pkg::SLANT_DIV);
    wire [4:0] step_half = 5'(({1'b0, rows_up} * 6'h02) / oca_pkg::SLANT_DIV);
    // Shift in half-dot units: five full steps or ten half steps
    wire [4:0] shift_h = ratio2 ? step_half : {step_full[3:0], 1'b0};
    wire italic_own = dot_i.code1[oca_pkg::C1_ITALIC_BIT];
    // A neighbour of an italic character is drawn slanted as well
    wire slant_on = is_cap && (italic_own || dot_i.prev_italic || dot_i.next_italic);
    // Position in half dots, offset so the left neighbour sits below 32
    wire [5:0] pos_h = {1'b1, dot_i.col, half_q & ratio2};
    wire [5:0] src_h = slant_on ? pos_h - {1'b0, shift_h} : pos_h;
    wire [31:0] pair_row = {dot_i.font_row, dot_i.prev_row};
    // Only the font sample moves; the cell and background stay put
    wire font_dot = pair_row[src_h[5:1]];

    // ---------------------------------------------------------------
    // Border detection from the unslanted font neighbourhood
    // ---------------------------------------------------------------
    wire [3:0] col = dot_i.col;
    wire left_n = (col == 4'h0) ? dot_i.prev_row[15] : dot_i.font_row[col - 4'h1];
    wire right_n = (col == 4'hF) ? dot_i.next_row[0] : dot_i.font_row[col + 4'h1];
    // Extended mode ignores the rows above and below on the top and bottom cell rows
    wire vert_ok = !(is_ext && (dot_i.row == 5'h00 || dot_i.row == oca_pkg::LAST_ROW));
    wire up_n = vert_ok && dot_i.above_row[col];
    wire down_n = vert_ok && dot_i.below_row[col];
    wire shadow = osd_ctrl_q[oca_pkg::OSD_SHADOW_BIT];
    // Shadow borders lie only right of and below the font
    wire near_font = shadow ? (left_n || up_n) : (left_n || right_n || up_n || down_n);
    wire border_en = blk_ctrl_q[oca_pkg::BLK_BORDER_BIT] && (is_pln || is_ext);
    wire in_block = dot_i.char_pos <= oca_pkg::LAST_CHAR;
    wire border_raw = border_en && dot_i.active && in_block && near_font;
    // Ratio 2 with 1.5-period dots stretches the border by one half dot
    logic border_hold_q;
    wire stretch = ratio2 && dot15;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            border_hold_q <= 1'b0;
        end else begin
            border_hold_q <= stretch && border_raw && half_q;
        end
    end
    wire border_dot = (border_raw || border_hold_q) && in_block;

    // ---------------------------------------------------------------
    // Colour decode
    // ---------------------------------------------------------------
    wire [2:0] fg_code = dot_i.code1[3:1];
    wire [2:0] bg_code = dot_i.code2[2:0];
    // Caption and plain modes take the bits straight; extended uses the table
    wire [2:0] fg_rgb = is_ext ? oca_pkg::EXT_COLOR_LUT[fg_code * 3 +: 3] : fg_code;
    wire [2:0] bg_rgb = is_ext ? oca_pkg::EXT_COLOR_LUT[bg_code * 3 +: 3] : bg_code;
    // Extra glyph, extended mode only
    wire [3:0] extra_sel = {dot_i.code2[oca_pkg::C2_EXTRA_BIT], dot_i.code1[7:5]};
    wire extra_dot = is_ext && dot_i.active && dot_i.extra_row[col];

    // ---------------------------------------------------------------
    // Attributes
    // ---------------------------------------------------------------
    wire uline_row = (dot_i.row == oca_pkg::ULINE_ROW_A) || (dot_i.row == oca_pkg::ULINE_ROW_B);
    wire uline_dot = is_cap && dot_i.code1[oca_pkg::C1_ULINE_BIT] && uline_row;
    wire flashing = is_cap && dot_i.code1[oca_pkg::C1_FLASH_BIT] && flash_off_q;
    wire bg_blank = flashing && osd_ctrl_q[oca_pkg::OSD_BGFLASH_BIT];
    wire fg_dot = dot_i.active && (font_dot || uline_dot) && !flashing;
    // Background only where nothing else paints
    wire bg_dot = dot_i.active && !(font_dot || uline_dot) && !border_dot && !extra_dot;

    // ---------------------------------------------------------------
    // Combine one pixel
    // ---------------------------------------------------------------
    wire [2:0] fg_part = fg_dot ? fg_rgb : 3'h0;
    wire [2:0] ex_part = extra_dot ? extra_col_q : 3'h0;
    // Font beats border, so border colour only where no font is lit
    wire [2:0] bd_part = (border_dot && !(font_dot || uline_dot)) ? border_col_q : 3'h0;
    wire [2:0] bg_part = (bg_dot && !bg_blank) ? bg_rgb : 3'h0;
    wire [2:0] rgb = fg_part | ex_part | bd_part | bg_part;
    wire luma_sel = dot_i.code1[oca_pkg::C1_LUMA_BIT];
    // Primary luma follows font (plus extra glyph and border) or the whole cell
    wire cell_on = dot_i.active && !bg_blank;
    wire luma_p = luma_sel ? cell_on : (fg_dot || extra_dot || bd_part != 3'h0);
    wire luma_s = blk_ctrl_q[oca_pkg::BLK_LUMA2_BIT] && luma_sel && cell_on;

    // Registered pixel, updated on every clock
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pix_o <= '0;
            extra_sel_o <= 4'h0;
        end else begin
            pix_o <= '{r: rgb[0], g: rgb[1], b: rgb[2],
                       luma_ctrl_primary: luma_p, luma_ctrl_secondary: luma_s};
            extra_sel_o <= is_ext ? extra_sel : 4'h0;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    fg_direct_a: assert property (is_cap && dot_i.active && font_dot && !slant_on && !flashing
        |=> {pix_o.b, pix_o.g, pix_o.r} == $past(dot_i.code1[3:1]))
        else $error("caption font colour not taken from code bits");
    ext_lut_a: assert property (is_ext && fg_dot && !extra_dot && fg_code == 3'h4
        |=> {pix_o.b, pix_o.g, pix_o.r} == 3'h3)
        else $error("extended code 100 must give red and green");
    bg_table_a: assert property (is_ext && bg_dot && bg_code == 3'h6 && !bg_blank
        |=> {pix_o.b, pix_o.g, pix_o.r} == 3'h6)
        else $error("extended background 110 must give green and blue");
    bg_exclusive_a: assert property (dot_i.active && border_dot && !font_dot && !uline_dot && !extra_dot
        |=> {pix_o.b, pix_o.g, pix_o.r} == $past(border_col_q))
        else $error("background mixed into border dot");
    uline_rows_a: assert property (is_cap && dot_i.active && dot_i.code1[6] && !flashing
        && dot_i.row == 5'h17 |=> pix_o.luma_ctrl_primary || $past(luma_sel))
        else $error("underline missing on row 24");
    flash_blank_a: assert property (flashing && !luma_sel |=> !pix_o.luma_ctrl_primary
        || $past(extra_dot))
        else $error("primary luma lit during flash off phase");
    flash_len_a: assert property (vsync_i && flash_cnt_q == 7'h2F && !flash_off_q
        |=> flash_off_q && flash_cnt_q == 7'h00)
        else $error("flash on phase not 48 vsync periods");
    flash_off_a: assert property (vsync_i && flash_cnt_q == 7'h0F && flash_off_q
        |=> !flash_off_q)
        else $error("flash off phase not 16 vsync periods");
    slant_top_a: assert property (slant_on && !ratio2 && dot_i.row == 5'h00
        |-> src_h == pos_h - 6'h0A)
        else $error("top row slant not five dots");
    border_off_a: assert property (!border_en ##1 !border_en |-> !border_dot)
        else $error("border shown while disabled");
    edge_border_a: assert property (dot_i.char_pos > 6'h27 |=> !(pix_o.luma_ctrl_primary
        && !$past(dot_i.active)))
        else $error("border past last character");
    luma2_gate_a: assert property (!blk_ctrl_q[7] |=> !pix_o.luma_ctrl_secondary)
        else $error("secondary luma without block enable");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    cov_italic_c: cover property (slant_on && ratio2 && font_dot);
    cov_border_c: cover property (border_dot && shadow ##1 pix_o.luma_ctrl_primary);
    cov_extra_c: cover property (extra_dot && fg_dot);
    cov_flash_c: cover property (flash_off_q && flashing);
endmodule : oca_char_attr
`default_nettype wire

// *** sim/oca_video_sink.sv ***
// Video path model that latches each rendered dot
`default_nettype none
module oca_video_sink (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic dot_tick,
    input wire oca_pkg::oca_pix_s pix,
    output oca_pkg::oca_pix_s pix_q
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------
    // Dot capture
    // ------------------------------------------------
    // Only ticked dots reach the screen, as in the real mixer
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pix_q <= '0;
        end else if (dot_tick) begin
            pix_q <= pix;
        end
    end
endmodule : oca_video_sink
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench of the character attribute renderer
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------
    // Signals
    // ------------------------------------------------
    localparam logic [23:0] LUT = 24'hEFECA0; // Extended table, {r,g,b} per code
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'hF; // Whole bytes only
    logic [31:0] wb_wdat = 32'h0;
    logic [31:0] wb_rdat;
    logic wb_ack;
    logic vsync = 1'b0;
    logic dot_tick;
    logic [3:0] extra_sel;
    oca_pkg::oca_dot_s dot_i = '0;
    oca_pkg::oca_dot_s dv = '0; // Dot being prepared
    oca_pkg::oca_pix_s pix;
    oca_pkg::oca_pix_s seen;
    int error_cnt = 0;
    int cmp_count = 0;
    logic [31:0] rd;
    logic [2:0] e;
    logic t0; // Earlier tick sample
    always #4 clk = ~clk;
    oca_char_attr DUT (.clk(clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .dot_i(dot_i), .vsync_i(vsync), .dot_tick_o(dot_tick), .extra_sel_o(extra_sel), .pix_o(pix));
    oca_video_sink sink (.clk(clk), .arst_n(arst_n), .dot_tick(dot_tick), .pix(pix), .pix_q(seen));
    // ------------------------------------------------
    // Tasks
    // ------------------------------------------------
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Single classic cycle; waits for ack, bounded
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_wdat <= wd;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        rd = wb_rdat;
        if (n >= 50) begin
            check("bus ack", 32'h0, 32'h1);
        end
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask : wb
    task automatic rchk(input logic [7:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, 32'h0);
        check("register", rd, exp);
    endtask : rchk
    // Present dv, let it pass the output register and the sink
    task automatic px(input string what, input logic [4:0] exp);
        @(posedge clk);
        dot_i <= dv;
        repeat (3) @(posedge clk);
        #1;
        check(what, {27'h0, seen}, {27'h0, exp});
    endtask : px
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge clk);
            vsync <= 1'b1;
            @(posedge clk);
            vsync <= 1'b0;
        end
    endtask : pulse
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up
    // ------------------------------------------------
    // Tests
    // ------------------------------------------------
    initial begin
        #200000;
        error_cnt++;
        wrap_up();
    end
    initial begin
        dv.active = 1'b1;
        dv.char_pos = 6'h03;
        dv.row = 5'h0A;
        dv.col = 4'h5;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        // All registers reset to zero, unmapped offset reads zero
        for (int i = 0; i < 5; i++) rchk(8'(i * 4), 32'h0);
        wb(1'b1, 8'h0C, 32'h5);
        rchk(8'h0C, 32'h5);
        wb(1'b1, 8'h20, 32'hFF);
        rchk(8'h20, 32'h0);
        $display("test registers done");
        // Font and background colour in caption, plain and extended modes and every code
        for (int m = 0; m < 3; m++) begin
            wb(1'b1, 8'h04, 32'(m << 4));
            for (int c = 0; c < 8; c++) begin
                e = 3'(c);
                dv.code1 = {4'h0, e, 1'b0};
                dv.code2 = {1'b0, ~e};
                dv.font_row = 16'h0020;
                px("font", {(m == 2) ? LUT[c * 3 +: 3] : {e[0], e[1], e[2]}, 2'b10});
                dv.font_row = 16'h0;
                px("background", {(m == 2) ? LUT[(7 - c) * 3 +: 3] : {~e[0], ~e[1], ~e[2]}, 2'b00});
            end
        end
        $display("test colours done");
        // Luma on whole cell, secondary gated by block bit 7
        wb(1'b1, 8'h04, 32'h80);
        dv.code1 = 8'h10;
        dv.code2 = 4'h0;
        px("luma both", 5'b00011);
        wb(1'b1, 8'h04, 32'h0);
        px("luma primary", 5'b00010);
        // Underline only on the two fixed rows
        dv.code1 = 8'h42;
        for (int r = 21; r < 25; r++) begin
            dv.row = 5'(r);
            px("underline", (r == 22 || r == 23) ? 5'b10010 : 5'b00000);
        end
        dv.row = 5'h0A;
        $display("test luma and underline done");
        // Flash: shown for 48 vsyncs, blanked for 16
        dv.code1 = 8'h22;
        dv.font_row = 16'h0020;
        pulse(47);
        px("flash on", 5'b10010);
        pulse(1);
        px("flash off", 5'b00000);
        rchk(8'h10, 32'h0000_0080);
        pulse(16);
        px("flash back", 5'b10010);
        $display("test flash done");
        // Italic in caption mode at ratio 1: the top row moves five dots right
        // Bench clock stands in for an 11-14 MHz overlay dot clock
        dv.code1 = 8'h82;
        dv.code2 = 4'h4;
        dv.row = 5'h00;
        dv.font_row = 16'h0001;
        px("italic top", 5'b10010);
        dv.col = 4'h0;
        px("italic cell kept", 5'b00100);
        dv.col = 4'h5;
        dv.code1 = 8'h02;
        dv.prev_italic = 1'b1;
        px("italic neighbour", 5'b10010);
        dv.prev_italic = 1'b0;
        px("upright", 5'b00100);
        dv.row = 5'h0A;
        dv.font_row = 16'h0020;
        $display("test italic done");
        // Pre-divider: steady tick at ratio 1, every second clock at ratio 2
        check("tick ratio 1", {31'h0, dot_tick}, 32'h1);
        wb(1'b1, 8'h04, 32'h1);
        @(posedge clk);
        #1;
        t0 = dot_tick;
        @(posedge clk);
        #1;
        check("tick ratio 2", {31'h0, t0 ^ dot_tick}, 32'h1);
        wb(1'b1, 8'h04, 32'h0);
        $display("test ratio done");
        // Extra glyph: screen-level control cleared first
        wb(1'b1, 8'h00, 32'h0);
        wb(1'b1, 8'h04, 32'h20);
        wb(1'b1, 8'h0C, 32'h4);
        dv.code1 = 8'hA2;
        dv.code2 = 4'h8;
        dv.extra_row = 16'h0020;
        px("extra or font", 5'b10110);
        check("extra select", {28'h0, extra_sel}, 32'hD);
        dv.font_row = 16'h0;
        px("extra alone", 5'b00110);
        dv.extra_row = 16'h0;
        $display("test extra done");
        // Border: colour, priority, shadow against full
        wb(1'b1, 8'h08, 32'h2);
        wb(1'b1, 8'h04, 32'h14);
        dv.code1 = 8'h02;
        dv.code2 = 4'h4;
        dv.font_row = 16'h0010;
        px("border right", 5'b01010);
        dv.font_row = 16'h0030;
        px("font over border", 5'b10010);
        dv.font_row = 16'h0;
        dv.below_row = 16'h0020;
        px("border top full", 5'b01010);
        wb(1'b1, 8'h00, 32'h4);
        px("no top in shadow", 5'b00100);
        dv.below_row = 16'h0;
        dv.above_row = 16'h0020;
        px("shadow bottom", 5'b01010);
        wb(1'b1, 8'h04, 32'h10);
        px("border off", 5'b00100);
        $display("test border done");
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
